// *** bench/area_select_encoder_speed_monitor_test.sv ***
// bench: registers, area decode, object drop and encoder trip
// assumes the ms tick is scaled to 20 clocks
`timescale 1ns/100ps
module area_select_encoder_speed_monitor_test;
  import area_speed_pkg::*;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, object_detected = 0, run = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        safety_out_1, safety_out_2, safety_out_3, safety_out_4;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic [3:0]  wstrb = 4'hF, safety_fb;
  logic [1:0]  bresp, rresp, gresp, enc_a, enc_b, fwd = 2'h1;
  logic [4:0]  off_mask = 5'h00, sel_norm, sel_inv, area_num;
  int          error_cnt = 0, compares = 0, cyc = 0;
  assign safety_fb = {safety_out_4, safety_out_3, safety_out_2, safety_out_1};
  area_select_encoder_speed_monitor #(.TICK_CYCLES(20), .TEST_CYCLES(8))
    u_area_select_encoder_speed_monitor (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .sel_norm,
    .sel_inv, .enc_a, .enc_b, .object_detected, .safety_fb, .safety_out_1,
    .safety_out_2, .safety_out_3, .safety_out_4, .area_num);
  enc_sw_model u_enc_sw_model (.aclk, .run, .fwd, .off_mask, .enc_a, .enc_b,
    .sel_norm, .sel_inv);
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin error_cnt++; wrap_up(); end
  end
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge aclk) {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
    do @(posedge aclk) begin
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b1;
    @(posedge aclk) bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    @(posedge aclk) {araddr, arvalid} <= {a, 1'b1};
    do @(posedge aclk) if (arready) arvalid <= 1'b0; while (!rvalid);
    rready <= 1'b1;
    @(posedge aclk) begin got = rdata; gresp = rresp; rready <= 1'b0; end
  endtask : rd
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_CTRL); chk(got, 32'h0000_1E05);
    rd(REG_PPC); chk(got, 32'h0040_0040);
    rd(6'h20); chk({gresp, got[29:0]}, {RESP_SLVERR, 30'h0});
    wr(REG_TOL, 32'h63); rd(REG_TOL); chk(got, 32'h0000_0050);
    $display("test registers done");
    for (int p = 1; p < 4; p++) begin
      wr(REG_CTRL, 32'h0000_0100 | p);
      for (int v = 0; v < 8; v++) begin
        off_mask <= 5'(v);
        repeat (60) @(posedge aclk);
        chk(area_num, v & ((1 << p) - 1));
      end
    end
    $display("test area decode done");
    for (int i = 0; i < 3000 && !safety_out_1; i++) @(posedge aclk);
    chk(safety_out_1, 1'b1);
    object_detected <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(safety_out_1, 1'b0);
    object_detected <= 1'b0;
    $display("test object done");
    wr(REG_PPC, 32'h0001_0001);
    run <= 1'b1;
    repeat (14000) @(posedge aclk);
    rd(REG_STATUS); chk(got & 32'h301, 32'h101);
    chk(safety_out_1, 1'b0);
    rd(REG_SPEED); chk(got & 32'h8000_8000, 32'h8000_0000);
    chk(32'(got[15:0] inside {16'h136, 16'h140}), 32'h1);
    $display("test encoders done");
    wr(REG_CTRL, 32'h0000_0108);
    wr(REG_PAT, 32'h0001_0301);
    off_mask <= 5'h01;
    repeat (60) @(posedge aclk);
    chk(area_num, 32'h3);
    $display("test encoder mode done");
    wrap_up();
  end
endmodule : area_select_encoder_speed_monitor_test

// *** bench/asesm_chk.sv ***
// checker: bus handshakes, output pairing and object drop
// assumes binding onto the monitor top module
`timescale 1ns/100ps
module asesm_chk (
  input wire logic        aclk, aresetn, awvalid, awready, wvalid,
  input wire logic        wready, bvalid, bready, arvalid, arready,
  input wire logic        rvalid, rready, object_detected, safety_out_1,
  input wire logic        safety_out_2, safety_out_3, safety_out_4,
  input wire logic [1:0]  bresp,
  input wire logic [31:0] rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_out12_same: assert property (safety_out_1 == safety_out_2)
    else $error("outputs 1 and 2 split");
  chk_out34_same: assert property (safety_out_3 == safety_out_4)
    else $error("outputs 3 and 4 split");
  chk_obj_drop: assert property (object_detected |=> !safety_out_1)
    else $error("output on with object");
  chk_b_answer: assert property (awvalid && awready && wvalid && wready
    |=> bvalid) else $error("no write response");
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_r_answer: assert property (arvalid && arready |=> rvalid)
    else $error("no read data");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_wr_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while busy");
  chk_rd_block: assert property (rvalid |-> !arready)
    else $error("read taken while busy");
endmodule : asesm_chk
bind area_select_encoder_speed_monitor asesm_chk u_chk (.aclk, .aresetn,
  .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready,
  .rvalid, .rready, .object_detected, .safety_out_1, .safety_out_2,
  .safety_out_3, .safety_out_4, .bresp, .rdata);

// *** bench/enc_sw_model.sv ***
// model: two quadrature encoders and complementary select switches
// assumes the bench sets motion, direction and the pairs switched off
`timescale 1ns/100ps
module enc_sw_model (
  input  wire logic       aclk,     // system clock
  input  wire logic       run,      // encoders turning
  input  wire logic [1:0] fwd,      // 1 = forward
  input  wire logic [4:0] off_mask, // pairs with normal line off
  output logic      [1:0] enc_a,    // channel one
  output logic      [1:0] enc_b,    // channel two
  output logic      [4:0] sel_norm, // normal lines
  output logic      [4:0] sel_inv   // inverse lines
);
  logic [3:0] cnt = 4'h0;
  logic [1:0] ph  = 2'h0;
  assign sel_norm = ~off_mask;
  assign sel_inv  = off_mask;
  assign enc_a    = {2{ph[1]}};
  // channel two leads by a quarter period when going forward
  assign enc_b    = {2{^ph}} ^ ~fwd;
  always @(posedge aclk) begin
    cnt <= cnt + 4'h1;
    if (run && cnt == 4'hF) ph <= ph + 2'h1;
  end
endmodule : enc_sw_model

// *** hw/area_select_encoder_speed_monitor.sv ***
// area selection from complementary input pairs, dual encoder speed
// monitoring and safety output drive, with an AXI4-Lite register slave.
// assumes select, encoder and feedback pins are asynchronous; the object
// detect input comes from logic on the same clock.
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// Contract
// - three pairs: normal OFF adds weights 1,2,4 to area one, eight areas
// - two pairs: weights 1 and 2, all normal ON gives area one
// - one pair: normal ON gives area one, normal OFF gives area two
// - two independent quadrature encoder inputs, both watched continuously
// - at channel one rising edge, channel two high is forward, low backward
// - vehicle speed is the larger of the two encoder speeds
// - permitted mismatch is configurable from zero to eighty percent
// - mismatch limit: none up to 9 cm/s, 60 s below 30, 20 s above
// - above 9 cm/s with opposite directions the limit is 0.3 s
// - mismatch longer than the allowed period turns safety outputs off
// - encoder mode: two inputs give four patterns, static/encoder/unused
// - fifth input option extends encoder mode to eight patterns
// - encoder pattern maps up to 32 speed ranges onto areas
// - measurable speed bounded by pulses per cm and 100 kHz
// - static pattern with monitoring: speed outside range turns outputs off
// - object in the protection zone turns safety outputs off
// - outputs pulsed off periodically; failed test holds them off
// - outputs one and two identical; three and four identical when used
// - non-complementary select pair raises an error
// - new select pattern acted on after settling delay, default 30 ms
module area_select_encoder_speed_monitor
  import area_speed_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S,
  parameter int unsigned TEST_CYCLES = CLK_HZ / US_PER_S * TEST_PULSE_US,
  parameter int unsigned N_RANGES    = 32
) (
  input  wire logic               aclk,          // system clock
  input  wire logic               aresetn,       // sync reset, active low
  input  wire logic [ADDR_W-1:0]  awaddr,        // write address
  input  wire logic               awvalid,       // write address valid
  output logic                    awready,       // write address ready
  input  wire logic [31:0]        wdata,         // write data
  input  wire logic [3:0]         wstrb,         // write byte strobes
  input  wire logic               wvalid,        // write data valid
  output logic                    wready,        // write data ready
  output logic [1:0]              bresp,         // write response
  output logic                    bvalid,        // write response valid
  input  wire logic               bready,        // write response ready
  input  wire logic [ADDR_W-1:0]  araddr,        // read address
  input  wire logic               arvalid,       // read address valid
  output logic                    arready,       // read address ready
  output logic [31:0]             rdata,         // read data
  output logic [1:0]              rresp,         // read response
  output logic                    rvalid,        // read data valid
  input  wire logic               rready,        // read data ready
  input  wire logic [4:0]         sel_norm,      // select pairs, normal line
  input  wire logic [4:0]         sel_inv,       // select pairs, inverse line
  input  wire logic [1:0]         enc_a,         // encoder channel one
  input  wire logic [1:0]         enc_b,         // encoder channel two
  input  wire logic               object_detected, // object in zone
  input  wire logic [3:0]         safety_fb,     // output level readback
  output logic                    safety_out_1,  // safety output 1
  output logic                    safety_out_2,  // safety output 2
  output logic                    safety_out_3,  // safety output 3
  output logic                    safety_out_4,  // safety output 4
  output logic [4:0]              area_num       // active area, 0 = area one
);

  typedef struct packed {
    logic [9:0]                  sel_s1, sel_s2;
    logic [3:0]                  enc_s1, enc_s2, enc_s3;
    logic [3:0]                  fb_s1, fb_s2;
    logic [2:0]                  pairs;
    logic                        enc_mode, fifth, out34;
    logic [7:0]                  delay_ms;
    logic [4:0]                  nrange;
    logic [6:0]                  tol;
    logic [15:0]                 ppc1, ppc2;
    logic [7:0][1:0]             pat_kind;
    logic [7:0][4:0]             pat_area;
    logic [7:0]                  pat_mon;
    logic [2:0]                  pat_sel;
    logic [15:0]                 lim_min, lim_max;
    logic [N_RANGES-1:0][15:0]   rng_bound;
    logic [N_RANGES-1:0][4:0]    rng_area;
    logic [4:0]                  rng_sel;
    logic [4:0]                  cand, pattern;
    logic [7:0]                  stable_ms;
    logic                        settled;
    logic [15:0]                 tick_cnt;
    logic [6:0]                  win_ms;
    logic [1:0][15:0]            pcnt;
    logic [1:0]                  dir;
    logic [1:0][15:0]            speed;
    logic                        ovr;
    logic [16:0]                 mis_ms;
    logic                        trip_mis, trip_lim, trip_pat, pair_err;
    logic [4:0]                  area;
    out_state_t                  ost;
    logic [15:0]                 test_cnt;
    logic [6:0]                  period_ms;
    logic                        so12, so34;
    logic                        awready, wready, bvalid, arready, rvalid;
    logic [1:0]                  bresp, rresp;
    logic [31:0]                 rdata;
    logic                        aw_hold, w_hold;
    logic [ADDR_W-1:0]           aw_addr;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;
  } state_t;

  state_t s_r, s_nxt;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic [16:0] abs16(input logic [15:0] v);
    logic [16:0] e;
    e = {v[15], v};
    return v[15] ? 17'(-e) : e;
  endfunction : abs16

  // pulses per window times windows per second, over pulses per cm
  function automatic logic [15:0] to_speed(input logic [15:0] cnt,
                                           input logic [15:0] ppc,
                                           input logic        fwd);
    logic [31:0] q;
    q = 32'h0;
    if (ppc != 16'h0)
      q = (32'(cnt) * 32'(WIN_PER_S)) / 32'(ppc);
    if (q > 32'h7FFF)
      q = 32'h7FFF;
    return fwd ? q[15:0] : 16'(-q[15:0]);
  endfunction : to_speed

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (data & m);
  endfunction : apply_strb

  function automatic logic [31:0] read_reg(input state_t s,
                                           input logic [ADDR_W-1:0] a);
    logic [31:0] d;
    d = 32'h0;
    case (a)
      REG_CTRL: begin
        d[CTRL_PAIRS_LSB +: 3] = s.pairs;
        d[CTRL_ENC_BIT]        = s.enc_mode;
        d[CTRL_FIFTH_BIT]      = s.fifth;
        d[CTRL_OUT34_BIT]      = s.out34;
        d[CTRL_DELAY_LSB +: 8] = s.delay_ms;
        d[CTRL_NRNG_LSB +: 5]  = s.nrange;
      end
      REG_TOL:   d[6:0] = s.tol;
      REG_PPC:   d = {s.ppc2, s.ppc1};
      REG_PAT: begin
        d[1:0]                = s.pat_kind[s.pat_sel];
        d[PAT_AREA_LSB +: 5]  = s.pat_area[s.pat_sel];
        d[PAT_MON_BIT]        = s.pat_mon[s.pat_sel];
        d[IDX_LSB +: 3]       = s.pat_sel;
      end
      REG_LIM:   d = {s.lim_max, s.lim_min};
      REG_RANGE: begin
        d[15:0]               = s.rng_bound[s.rng_sel];
        d[IDX_LSB +: 5]       = s.rng_sel;
        d[RNG_AREA_LSB +: 5]  = s.rng_area[s.rng_sel];
      end
      REG_STATUS: d = {11'h0, s.area, 4'h0, s.ost, s.dir,
                       s.so34, s.so12, s.settled, s.ovr, s.trip_pat,
                       s.pair_err, s.trip_lim, s.trip_mis};
      REG_SPEED: d = {s.speed[1], s.speed[0]};
      default:   d = 32'h0;
    endcase
    return d;
  endfunction : read_reg

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    return a <= REG_SPEED && a[1:0] == 2'h0;
  endfunction : reg_hit

  function automatic state_t reset_state();
    state_t r;
    r          = '0;
    r.pairs    = PAIRS_RST;
    r.delay_ms = DELAY_RST;
    r.ppc1     = PPC_RST;
    r.ppc2     = PPC_RST;
    r.lim_min  = LIM_MIN_RST;
    r.lim_max  = LIM_MAX_RST;
    r.ost      = OUT_RUN;
    return r;
  endfunction : reset_state

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic        ms, rise, opp, mism, in_rng, safe;
    logic [4:0]  mask, raw;
    logic [2:0]  pidx;
    logic [1:0]  kind;
    logic [16:0] m0, m1, vmax, diff, lim;
    logic [15:0] v;
    logic [4:0]  enc_area;
    wv = 32'h0; ms = 1'h0; rise = 1'h0; opp = 1'h0; mism = 1'h0;
    in_rng = 1'h0; safe = 1'h0; mask = 5'h0; raw = 5'h0; pidx = 3'h0;
    kind = PAT_UNUSED; m0 = 17'h0; m1 = 17'h0; vmax = 17'h0;
    diff = 17'h0; lim = 17'h0; v = 16'h0; enc_area = 5'h0;
    s_nxt = s_r;

    // pins pass two flops before anything reads them
    s_nxt.sel_s1 = {sel_inv, sel_norm};
    s_nxt.sel_s2 = s_r.sel_s1;
    s_nxt.enc_s1 = {enc_b, enc_a};
    s_nxt.enc_s2 = s_r.enc_s1;
    s_nxt.enc_s3 = s_r.enc_s2;
    s_nxt.fb_s1  = safety_fb;
    s_nxt.fb_s2  = s_r.fb_s1;

    // ---------------- register bus: write ------------------------------
    if (awvalid && s_r.awready) begin
      s_nxt.aw_hold = 1'h1;
      s_nxt.aw_addr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_hold = 1'h1;
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
    end
    if (s_r.bvalid && bready)
      s_nxt.bvalid = 1'h0;
    if (s_nxt.aw_hold && s_nxt.w_hold && !s_r.bvalid) begin
      wv = apply_strb(read_reg(s_r, s_nxt.aw_addr), s_nxt.w_data,
                      s_nxt.w_strb);
      s_nxt.aw_hold = 1'h0;
      s_nxt.w_hold  = 1'h0;
      s_nxt.bvalid  = 1'h1;
      s_nxt.bresp   = reg_hit(s_nxt.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (s_nxt.aw_addr)
        REG_CTRL: begin
          s_nxt.pairs    = wv[CTRL_PAIRS_LSB +: 3];
          s_nxt.enc_mode = wv[CTRL_ENC_BIT];
          s_nxt.fifth    = wv[CTRL_FIFTH_BIT];
          s_nxt.out34    = wv[CTRL_OUT34_BIT];
          s_nxt.delay_ms = wv[CTRL_DELAY_LSB +: 8];
          s_nxt.nrange   = wv[CTRL_NRNG_LSB +: 5];
        end
        // tolerance clamps at the top of its range
        REG_TOL: s_nxt.tol = (32'(wv[6:0]) > TOL_MAX_PCT) ?
                             7'(TOL_MAX_PCT) : wv[6:0];
        REG_PPC: {s_nxt.ppc2, s_nxt.ppc1} = wv;
        REG_PAT: begin
          pidx = wv[IDX_LSB +: 3];
          s_nxt.pat_sel        = pidx;
          s_nxt.pat_kind[pidx] = wv[1:0];
          s_nxt.pat_area[pidx] = wv[PAT_AREA_LSB +: 5];
          s_nxt.pat_mon[pidx]  = wv[PAT_MON_BIT];
        end
        REG_LIM: {s_nxt.lim_max, s_nxt.lim_min} = wv;
        REG_RANGE: begin
          s_nxt.rng_sel = wv[IDX_LSB +: 5];
          s_nxt.rng_bound[wv[IDX_LSB +: 5]] = wv[15:0];
          s_nxt.rng_area[wv[IDX_LSB +: 5]]  = wv[RNG_AREA_LSB +: 5];
        end
        REG_STATUS:
          if (wv[ST_CLR_BIT])
            s_nxt.trip_mis = 1'h0;
        default: ;
      endcase
    end
    s_nxt.awready = !s_nxt.aw_hold && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_hold && !s_nxt.bvalid;

    // ---------------- register bus: read -------------------------------
    if (s_r.rvalid && rready)
      s_nxt.rvalid = 1'h0;
    if (arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'h1;
      s_nxt.rdata  = read_reg(s_r, araddr);
      s_nxt.rresp  = reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    s_nxt.arready = !s_nxt.rvalid;

    // ---------------- millisecond time base ----------------------------
    ms = s_r.tick_cnt == 16'(TICK_CYCLES - 1);
    s_nxt.tick_cnt = ms ? 16'h0 : 16'(s_r.tick_cnt + 16'h1);

    // ---------------- area select --------------------------------------
    // in encoder mode the fifth pair is the extra pattern bit
    if (s_r.enc_mode)
      mask = {s_r.fifth, 2'h0, 2'h3};
    else
      mask = 5'((6'h1 << s_r.pairs) - 6'h1);
    s_nxt.pair_err = |(~(s_r.sel_s2[4:0] ^ s_r.sel_s2[9:5]) & mask);
    raw = ~s_r.sel_s2[4:0] & mask;
    if (s_r.enc_mode)
      raw = {2'h0, raw[4], raw[1:0]};
    // a change restarts the settling count
    if (raw != s_r.cand) begin
      s_nxt.cand      = raw;
      s_nxt.stable_ms = 8'h0;
    end else if (s_r.stable_ms >= s_r.delay_ms) begin
      s_nxt.pattern = s_r.cand;
      s_nxt.settled = 1'h1;
    end else if (ms)
      s_nxt.stable_ms = 8'(s_r.stable_ms + 8'h1);

    // ---------------- encoders ------------------------------------------
    for (int i = 0; i < 2; i++) begin
      rise = s_r.enc_s2[i] && !s_r.enc_s3[i];
      if (rise)
        s_nxt.dir[i] = s_r.enc_s2[i + 2];
      if (rise && s_r.pcnt[i] != 16'hFFFF)
        s_nxt.pcnt[i] = 16'(s_r.pcnt[i] + 16'h1);
    end
    if (ms) begin
      s_nxt.win_ms = 7'(s_r.win_ms + 7'h1);
      if (s_r.win_ms == 7'(WINDOW_MS - 1)) begin
        s_nxt.win_ms   = 7'h0;
        s_nxt.speed[0] = to_speed(s_r.pcnt[0], s_r.ppc1, s_r.dir[0]);
        s_nxt.speed[1] = to_speed(s_r.pcnt[1], s_r.ppc2, s_r.dir[1]);
        // beyond the encoder's top frequency speed is not measurable
        s_nxt.ovr = (32'(s_r.pcnt[0]) > MAX_WIN_PULSES) ||
                    (32'(s_r.pcnt[1]) > MAX_WIN_PULSES);
        s_nxt.pcnt = '0;
      end
    end

    // ---------------- mismatch supervision ------------------------------
    m0   = abs16(s_r.speed[0]);
    m1   = abs16(s_r.speed[1]);
    vmax = (m0 >= m1) ? m0 : m1;
    v    = (m0 >= m1) ? s_r.speed[0] : s_r.speed[1];
    diff = abs16(16'(s_r.speed[0] - s_r.speed[1]));
    mism = 32'(diff) * PCT_FULL > 32'(s_r.tol) * 32'(vmax);
    opp  = (s_r.dir[0] != s_r.dir[1]) && m0 != 17'h0 && m1 != 17'h0;
    if (32'(vmax) <= SLOW_CMS)
      lim = 17'h1FFFF;
    else if (opp)
      lim = 17'(T_OPP_MS);
    else if (32'(vmax) >= FAST_CMS)
      lim = 17'(T_FAST_MS);
    else
      lim = 17'(T_MID_MS);
    if (!mism)
      s_nxt.mis_ms = 17'h0;
    else if (ms && s_r.mis_ms != 17'h1FFFF)
      s_nxt.mis_ms = 17'(s_r.mis_ms + 17'h1);
    // the trip is sticky; a set in the clearing cycle wins
    if (mism && 32'(vmax) > SLOW_CMS && s_r.mis_ms > lim)
      s_nxt.trip_mis = 1'h1;

    // ---------------- pattern and area ----------------------------------
    enc_area = s_r.rng_area[s_r.nrange];
    for (int i = N_RANGES - 1; i >= 0; i--)
      if (5'(i) <= s_r.nrange && $signed(v) <= $signed(s_r.rng_bound[i]))
        enc_area = s_r.rng_area[i];
    kind = s_r.pat_kind[s_r.pattern[2:0]];
    s_nxt.trip_pat = 1'h0;
    s_nxt.trip_lim = 1'h0;
    if (!s_r.enc_mode)
      s_nxt.area = s_r.pattern;
    else begin
      case (kind)
        PAT_STATIC: begin
          s_nxt.area = s_r.pat_area[s_r.pattern[2:0]];
          in_rng = $signed(v) >= $signed(s_r.lim_min) &&
                   $signed(v) <= $signed(s_r.lim_max);
          s_nxt.trip_lim = s_r.pat_mon[s_r.pattern[2:0]] && !in_rng;
        end
        PAT_ENCODER: s_nxt.area = enc_area;
        default:     s_nxt.trip_pat = 1'h1;
      endcase
    end

    // ---------------- output test and drive -----------------------------
    case (s_r.ost)
      OUT_RUN: begin
        if (ms)
          s_nxt.period_ms = 7'(s_r.period_ms + 7'h1);
        if (s_r.period_ms == 7'(TEST_PERIOD_MS)) begin
          s_nxt.period_ms = 7'h0;
          s_nxt.test_cnt  = 16'h0;
          s_nxt.ost       = OUT_TEST;
        end
      end
      OUT_TEST: begin
        s_nxt.test_cnt = 16'(s_r.test_cnt + 16'h1);
        // readback must have fallen by the end of the off pulse
        if (s_r.test_cnt == 16'(TEST_CYCLES - 1))
          s_nxt.ost = ((s_r.fb_s2[1:0] != 2'h0) ||
                       (s_r.out34 && s_r.fb_s2[3:2] != 2'h0)) ?
                      OUT_LOCK : OUT_RUN;
      end
      OUT_LOCK: s_nxt.ost = OUT_LOCK;
      default:  s_nxt.ost = OUT_LOCK;
    endcase
    safe = !object_detected && !s_r.pair_err && !s_r.trip_mis &&
           !s_r.trip_lim && !s_r.trip_pat && !s_r.ovr && s_r.settled &&
           s_r.ost == OUT_RUN;
    s_nxt.so12 = safe;
    s_nxt.so34 = safe && s_r.out34;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      s_r <= reset_state();
    else
      s_r <= s_nxt;
  end

  // ---------------------------------------------------------------------
  // outputs straight from the state register
  // ---------------------------------------------------------------------
  assign awready      = s_r.awready;
  assign wready       = s_r.wready;
  assign bvalid       = s_r.bvalid;
  assign bresp        = s_r.bresp;
  assign arready      = s_r.arready;
  assign rvalid       = s_r.rvalid;
  assign rdata        = s_r.rdata;
  assign rresp        = s_r.rresp;
  assign safety_out_1 = s_r.so12;
  assign safety_out_2 = s_r.so12;
  assign safety_out_3 = s_r.so34;
  assign safety_out_4 = s_r.so34;
  assign area_num     = s_r.area;

endmodule : area_select_encoder_speed_monitor

// *** pkg/area_speed_pkg.sv ***
// constants, register map and field layout for the area select and
// encoder speed monitor.
// assumes a single 20 MHz clock and an AXI4-Lite master for the registers.
package area_speed_pkg;

  // ---------------------------------------------------------------------
  // clock and time base
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned US_PER_S      = 1_000_000;
  localparam int unsigned TEST_PULSE_US = 300;
  localparam int unsigned TEST_PERIOD_MS = 100;
  localparam int unsigned WINDOW_MS     = 100;
  localparam int unsigned WIN_PER_S     = MS_PER_S / WINDOW_MS;
  localparam int unsigned ENC_FMAX_HZ   = 100_000;
  localparam int unsigned MAX_WIN_PULSES = ENC_FMAX_HZ / WIN_PER_S;

  // ---------------------------------------------------------------------
  // mismatch tolerance and speed bands
  // ---------------------------------------------------------------------
  localparam int unsigned TOL_MAX_PCT = 80;
  localparam int unsigned PCT_FULL    = 100;
  localparam int unsigned SLOW_CMS    = 9;
  localparam int unsigned FAST_CMS    = 30;
  localparam int unsigned T_OPP_MS    = 300;
  localparam int unsigned T_MID_MS    = 60_000;
  localparam int unsigned T_FAST_MS   = 20_000;

  // ---------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] REG_CTRL   = 6'h00;
  localparam logic [5:0] REG_TOL    = 6'h04;
  localparam logic [5:0] REG_PPC    = 6'h08;
  localparam logic [5:0] REG_PAT    = 6'h0C;
  localparam logic [5:0] REG_LIM    = 6'h10;
  localparam logic [5:0] REG_RANGE  = 6'h14;
  localparam logic [5:0] REG_STATUS = 6'h18;
  localparam logic [5:0] REG_SPEED  = 6'h1C;

  // field positions
  localparam int unsigned CTRL_PAIRS_LSB = 0;
  localparam int unsigned CTRL_ENC_BIT   = 3;
  localparam int unsigned CTRL_FIFTH_BIT = 4;
  localparam int unsigned CTRL_OUT34_BIT = 5;
  localparam int unsigned CTRL_DELAY_LSB = 8;
  localparam int unsigned CTRL_NRNG_LSB  = 16;
  localparam int unsigned HALF_LSB       = 16;
  localparam int unsigned IDX_LSB        = 16;
  localparam int unsigned PAT_AREA_LSB   = 8;
  localparam int unsigned PAT_MON_BIT    = 13;
  localparam int unsigned RNG_AREA_LSB   = 24;
  localparam int unsigned ST_CLR_BIT     = 0;

  // reset values
  localparam logic [2:0]  PAIRS_RST = 3'h5;
  localparam logic [7:0]  DELAY_RST = 8'h1E;
  localparam logic [15:0] PPC_RST   = 16'h0040;
  localparam logic [15:0] LIM_MIN_RST = 16'h8000;
  localparam logic [15:0] LIM_MAX_RST = 16'h7FFF;

  // pattern kinds and bus answers
  localparam logic [1:0] PAT_UNUSED  = 2'h0;
  localparam logic [1:0] PAT_STATIC  = 2'h1;
  localparam logic [1:0] PAT_ENCODER = 2'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {OUT_RUN, OUT_TEST, OUT_LOCK} out_state_t;

endpackage : area_speed_pkg
